/* File: bench/adcsq_assertions.sv */
// Purpose: port-level properties of the converter control block
// Assumes: one clock, synchronous active-low reset, sel[0] always set
// Notes: attached by bind from the testbench file
module adcsq_assertions
	import adcsq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic halt_mode,
	input wire logic [15:0] analog_input_pin,
	input wire logic [15:0] pin_digital_level,
	input wire logic [3:0] mux_sel,
	input wire logic sample,
	input wire logic converter_power
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic wr_ctrl;
	logic [3:0] ch_q;
	assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
		&& wb_adr_i[9:0] == ADCSQ_ADR_CTRL;
	// shadow of the channel field, updated on the taking edge
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ch_q <= 4'h0;
		else if (wr_ctrl)
			ch_q <= wb_dat_i[3:0];
	end
	property p_start;
		$rose(converter_power) |-> ##[0:16] sample;
	endproperty
	a_start: assert property (p_start) else $error("no sampling after on");
	property p_stop;
		// sample lags the sequencer by one more register than the power flag
		wr_ctrl && !wb_dat_i[ADCSQ_BIT_ON] |-> ##3 !converter_power && !sample;
	endproperty
	a_stop: assert property (p_stop) else $error("converter kept running");
	property p_channel;
		// a channel write needs three cycles to reach the mux output
		$rose(sample) && !$past(wr_ctrl) && !$past(wr_ctrl, 2)
			|-> mux_sel == ch_q;
	endproperty
	a_channel: assert property (p_channel) else $error("wrong input sampled");
	property p_restart;
		wr_ctrl && wb_dat_i[ADCSQ_BIT_ON] && converter_power && !halt_mode
			&& wb_dat_i[3:0] != ch_q |-> ##3 sample && mux_sel == ch_q;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_low_zero;
		wb_ack_o && !wb_we_i && wb_adr_i[9:0] == ADCSQ_ADR_RES_LOW
			|-> wb_dat_o[31:2] == 30'h0;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("low pad bits set");
	property p_reset;
		$rose(rst_n) |-> !converter_power && !sample && mux_sel == 4'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared");
	property p_pins;
		$past(rst_n) |-> pin_digital_level == $past(analog_input_pin);
	endproperty
	a_pins: assert property (p_pins) else $error("pin level not copied");
	property p_halt;
		halt_mode ##1 halt_mode ##1 halt_mode |-> !converter_power && !sample;
	endproperty
	a_halt: assert property (p_halt) else $error("powered in halt");
	c_write: cover property (wr_ctrl && wb_dat_i[ADCSQ_BIT_ON]);
	c_sample: cover property ($rose(sample));
	c_halt: cover property (halt_mode ##1 halt_mode);
endmodule // adcsq_assertions

/* File: bench/adcsq_core_model.sv */
// Purpose: behavioural analog core and input multiplexer
// Assumes: comparator settles within the cpu cycle of the trial code
// Notes: per-channel level and out-of-range flags come from the bench
module adcsq_core_model
(
	input wire logic [3:0] mux_sel,
	input wire logic [9:0] trial,
	input wire logic [15:0][9:0] level,
	input wire logic [15:0] over,
	input wire logic [15:0] under,
	output logic cmp_high,
	output logic cmp_above,
	output logic cmp_below
);
	timeunit 1ns;
	timeprecision 1ps;
	// out-of-range inputs still steer every trial the same way
	assign cmp_above = over[mux_sel];
	// analog pins act as plain inputs: no pull-up, no pin interrupt
	assign cmp_below = under[mux_sel];
	assign cmp_high = !cmp_below && (cmp_above || level[mux_sel] >= trial);
endmodule // adcsq_core_model

/* File: bench/testbench.sv */
// Purpose: register-level tests of the converter control block
// Assumes: classic wishbone master, one request at a time
// Notes: analog values come from the behavioural core model
module testbench
	import adcsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic halt_mode, wait_mode, cmp_high, cmp_above, cmp_below;
	logic sample, converter_power;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i, mux_sel;
	logic [9:0] trial, expv;
	logic [15:0] analog_input_pin, pin_digital_level, over, under;
	logic [15:0][9:0] level;
	logic [7:0] q, slow, fast;
	int err_total, tests_run;
	adcsq_top uut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .halt_mode, .wait_mode,
		.cmp_high, .cmp_above, .cmp_below, .analog_input_pin,
		.pin_digital_level, .mux_sel, .sample, .trial, .converter_power);
	adcsq_core_model core (.mux_sel, .trial, .level, .over, .under,
		.cmp_high, .cmp_above, .cmp_below);
	// ----
	// bus access and checking
	// ----
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {22'h0, a};
		wb_dat_i <= {24'h0, d};
		@(posedge clk);
		while (wb_ack_o !== 1'b1)
			@(posedge clk);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask
	task automatic poll;
		q = 8'h00;
		while (q[ADCSQ_BIT_DONE] !== 1'b1)
			wb(1'b0, ADCSQ_ADR_CTRL, 8'h00);
	endtask
	// length of one sample phase in cpu cycles
	task automatic width(output logic [7:0] n);
		n = 8'h00;
		@(posedge sample);
		@(posedge clk);
		while (sample === 1'b1)
		begin
			n++;
			@(posedge clk);
		end
	endtask
	task automatic test_done;
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		test_done;
	end
	// ----
	// test sequence
	// ----
	initial
	begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, halt_mode, wait_mode} = 6'h00;
		wb_adr_i = 32'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		analog_input_pin = 16'ha5c3;
		over = 16'h0020;
		under = 16'h0040;
		err_total = 0;
		tests_run = 0;
		for (int i = 0; i < 16; i++)
			level[i] = 10'(i * 61 + 7);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADCSQ_ADR_CTRL, 8'h00);
		rd(ADCSQ_ADR_RES_HIGH, 8'h00);
		rd(ADCSQ_ADR_RES_LOW, 8'h00);
		wb(1'b1, 10'h3fc, 8'hff);
		rd(10'h3fc, 8'h00);
		wb(1'b1, ADCSQ_ADR_CTRL, 8'hc5);
		rd(ADCSQ_ADR_CTRL, 8'h45);
		wb(1'b1, ADCSQ_ADR_RES_HIGH, 8'h55);
		rd(ADCSQ_ADR_RES_HIGH, 8'h00);
		wb(1'b1, ADCSQ_ADR_CTRL, 8'h20);
		// first phase after switch-on starts at a free divider phase
		width(slow);
		width(slow);
		wb(1'b1, ADCSQ_ADR_CTRL, 8'h60);
		width(fast);
		chk(slow, fast << 1);
		chk(fast, 8'(ADCSQ_SAMPLE_TICKS * 2));
		analog_input_pin <= 16'h3c5a;
		wait_mode <= 1'b1;
		// descending so every write really changes the channel
		for (int c = 15; c >= 0; c--)
		begin
			expv = over[c] ? 10'h3ff : under[c] ? 10'h000 : level[c];
			wb(1'b1, ADCSQ_ADR_CTRL, 8'h60 | 8'(c));
			rd(ADCSQ_ADR_CTRL, 8'h60 | 8'(c));
			poll;
			rd(ADCSQ_ADR_RES_LOW, {6'h00, expv[1:0]});
			rd(ADCSQ_ADR_RES_HIGH, expv[9:2]);
			rd(ADCSQ_ADR_CTRL, 8'h60 | 8'(c));
		end
		poll;
		rd(ADCSQ_ADR_RES_HIGH, level[0][9:2]);
		rd(ADCSQ_ADR_CTRL, 8'h60);
		level[0] <= 10'h155;
		width(q);
		width(q);
		rd(ADCSQ_ADR_RES_LOW, 8'h01);
		rd(ADCSQ_ADR_RES_HIGH, 8'h55);
		halt_mode <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADCSQ_ADR_POWER, 8'h01);
		halt_mode <= 1'b0;
		wb(1'b1, ADCSQ_ADR_CTRL, 8'h40);
		repeat (60) @(posedge clk);
		rd(ADCSQ_ADR_CTRL, 8'h40);
		rd(ADCSQ_ADR_RES_HIGH, 8'h55);
		test_done;
	end
endmodule // testbench
bind adcsq_top adcsq_assertions chk (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .halt_mode,
	.analog_input_pin, .pin_digital_level, .mux_sel, .sample,
	.converter_power);

/* File: common/adcsq_core_if.sv */
// Purpose: carries the control and result between the register file
// Assumes: one clock domain
// Notes: sequencer drives results, register file drives controls
interface adcsq_core_if;
	logic enable;
	logic speed;
	logic restart;
	logic [3:0] channel;
	logic done;
	logic [9:0] result;

	modport ctrl (
		output enable,
		output speed,
		output restart,
		output channel,
		input done,
		input result
	);

	modport seq (
		input enable,
		input speed,
		input restart,
		input channel,
		output done,
		output result
	);
endinterface

/* File: common/adcsq_pkg.sv */
// Purpose: shared constants and types for the converter sequencer control
// Assumes: 32-bit classic wishbone, byte address = 4 * register index
// Notes: register indices are kept as printed, see offsets below
package adcsq_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADCSQ_IDX_CTRL = 8'h70;
	localparam logic [7:0] ADCSQ_IDX_RES_HIGH = 8'h71;
	localparam logic [7:0] ADCSQ_IDX_RES_LOW = 8'h72;
	localparam logic [7:0] ADCSQ_IDX_POWER = 8'h73;
	localparam int ADCSQ_ADR_W = 10;
	localparam logic [9:0] ADCSQ_ADR_CTRL = {ADCSQ_IDX_CTRL, 2'b00};
	localparam logic [9:0] ADCSQ_ADR_RES_HIGH = {ADCSQ_IDX_RES_HIGH, 2'b00};
	localparam logic [9:0] ADCSQ_ADR_RES_LOW = {ADCSQ_IDX_RES_LOW, 2'b00};
	localparam logic [9:0] ADCSQ_ADR_POWER = {ADCSQ_IDX_POWER, 2'b00};

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int ADCSQ_BIT_DONE = 7;
	localparam int ADCSQ_BIT_SPEED = 6;
	localparam int ADCSQ_BIT_ON = 5;
	localparam int ADCSQ_BIT_RSVD = 4;
	localparam int ADCSQ_CH_MSB = 3;
	localparam int ADCSQ_BIT_HALT = 0;
	localparam logic [7:0] ADCSQ_CTRL_RESET = 8'h00;
	localparam logic [9:0] ADCSQ_RESULT_RESET = 10'h000;
	localparam logic [9:0] ADCSQ_RESULT_MAX = 10'h3ff;
	localparam logic [9:0] ADCSQ_RESULT_MIN = 10'h000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int ADCSQ_RES_BITS = 10;
	// converter clock periods per conversion: sample, ten bit trials, result stored on the last trial
	localparam int ADCSQ_SAMPLE_TICKS = 2;
	localparam logic [3:0] ADCSQ_SAMPLE_LAST = 4'h1;
	localparam logic [3:0] ADCSQ_BIT_LAST = 4'h9;
	localparam logic [1:0] ADCSQ_DIV_SLOW_LAST = 2'h3;
	localparam logic [1:0] ADCSQ_DIV_FAST_LAST = 2'h1;

	typedef enum logic [1:0] {
		ADCSQ_IDLE,
		ADCSQ_SAMPLE,
		ADCSQ_CONVERT
	} adcsq_state_type;

endpackage

/* File: src/adcsq_seq.sv */
// Purpose: successive approximation sequencer driving the analog core
// Assumes: comparator answers within one cpu clock of the trial code
// Notes: converter tick is cpu clock divided by four or two
module adcsq_seq
	import adcsq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	adcsq_core_if.seq cif,
	output logic [3:0] mux_sel,
	output logic sample,
	output logic [9:0] trial,
	input wire logic cmp_high,
	input wire logic cmp_above,
	input wire logic cmp_below
);

	typedef struct packed {
		adcsq_state_type st;
		logic [1:0] div;
		logic [3:0] cnt;
		logic [9:0] sar;
		logic [9:0] bitm;
		logic [3:0] ch;
		logic done;
		logic [9:0] result;
	} adcsq_seq_type;

	adcsq_seq_type r_q, r_d;
	logic tick;

	always_comb
	begin
		r_d = r_q;
		r_d.done = 1'b0;
		tick = (r_q.div == (cif.speed ? ADCSQ_DIV_FAST_LAST
			: ADCSQ_DIV_SLOW_LAST));
		r_d.div = tick ? 2'h0 : r_q.div + 2'h1;
		unique case (r_q.st)
			ADCSQ_IDLE:
			begin
				if (cif.enable)
				begin
					r_d.st = ADCSQ_SAMPLE;
					r_d.cnt = 4'h0;
					r_d.ch = cif.channel;
				end
			end
			ADCSQ_SAMPLE:
			begin
				if (tick)
				begin
					r_d.cnt = r_q.cnt + 4'h1;
					if (r_q.cnt == ADCSQ_SAMPLE_LAST)
					begin
						r_d.st = ADCSQ_CONVERT;
						r_d.cnt = 4'h0;
						r_d.bitm = 10'h200;
						r_d.sar = 10'h200;
					end
				end
			end
			ADCSQ_CONVERT:
			begin
				if (tick)
				begin
					r_d.sar = r_q.sar & ~(cmp_high ? 10'h000 : r_q.bitm);
					r_d.bitm = r_q.bitm >> 1;
					r_d.sar = r_d.sar | (r_q.bitm >> 1);
					r_d.cnt = r_q.cnt + 4'h1;
					if (r_q.cnt == ADCSQ_BIT_LAST)
					begin
						// saturate out-of-range inputs, no overflow flag
						if (cmp_above)
							r_d.result = ADCSQ_RESULT_MAX;
						else if (cmp_below)
							r_d.result = ADCSQ_RESULT_MIN;
						else
							r_d.result = r_d.sar;
						r_d.done = 1'b1;
						r_d.st = ADCSQ_SAMPLE;
						r_d.cnt = 4'h0;
						r_d.ch = cif.channel;
					end
				end
			end
			default:
				r_d.st = ADCSQ_IDLE;
		endcase
		// restart on channel change, stop when switched off
		if (cif.restart)
		begin
			r_d.st = ADCSQ_SAMPLE;
			r_d.cnt = 4'h0;
			r_d.ch = cif.channel;
			r_d.done = 1'b0;
		end
		if (!cif.enable)
		begin
			r_d.st = ADCSQ_IDLE;
			r_d.done = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			r_q <= '0;
			r_q.st <= ADCSQ_IDLE;
			r_q.result <= ADCSQ_RESULT_RESET;
		end
		else
			r_q <= r_d;
	end

	assign cif.done = r_q.done;
	assign cif.result = r_q.result;
	assign mux_sel = r_q.ch;
	assign sample = (r_q.st == ADCSQ_SAMPLE);
	assign trial = r_q.sar;

endmodule // adcsq_seq

/* File: src/adcsq_top.sv */
// Purpose: register file and bus slave of the converter sequencer control
// Assumes: classic wishbone, 32-bit data, registers in low byte lanes
// Notes: one wait state on every access; unmapped addresses read zero
//
// Decided for this implementation: the Wishbone interface to the registers.
module adcsq_top
	import adcsq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic halt_mode,
	input wire logic wait_mode,
	input wire logic cmp_high,
	input wire logic cmp_above,
	input wire logic cmp_below,
	input wire logic [15:0] analog_input_pin,
	output logic [15:0] pin_digital_level,
	output logic [3:0] mux_sel,
	output logic sample,
	output logic [9:0] trial,
	output logic converter_power
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic done;
		logic speed;
		logic on;
		logic rsvd;
		logic [3:0] ch;
		logic restart;
		logic ack;
		logic [31:0] dat;
		logic [15:0] pins;
		logic [3:0] mux;
		logic samp;
		logic [9:0] trial;
		logic power;
	} adcsq_top_type;

	adcsq_top_type r_q, r_d;
	adcsq_core_if cif();
	logic [3:0] seq_mux;
	logic seq_sample;
	logic [9:0] seq_trial;
	logic req;
	logic wr;
	logic rd;
	logic [9:0] adr;
	logic [7:0] wbyte;

	assign req = wb_cyc_i && wb_stb_i && !r_q.ack;
	assign wr = req && wb_we_i;
	assign rd = req && !wb_we_i;
	assign adr = wb_adr_i[ADCSQ_ADR_W-1:0];
	assign wbyte = wb_dat_i[7:0];

	// halt gates the converter off; wait mode is deliberately ignored
	assign cif.enable = r_q.on && !halt_mode;
	assign cif.speed = r_q.speed;
	assign cif.restart = r_q.restart;
	assign cif.channel = r_q.ch;

	adcsq_seq u_seq (
		.clk(clk),
		.rst_n(rst_n),
		.cif(cif),
		.mux_sel(seq_mux),
		.sample(seq_sample),
		.trial(seq_trial),
		.cmp_high(cmp_high),
		.cmp_above(cmp_above),
		.cmp_below(cmp_below)
	);

	// ----------------------------------------------------------------
	// register file and bus slave
	// ----------------------------------------------------------------
	always_comb
	begin
		r_d = r_q;
		r_d.ack = req;
		r_d.restart = 1'b0;
		r_d.dat = 32'h0000_0000;
		r_d.pins = analog_input_pin;
		r_d.mux = seq_mux;
		r_d.samp = seq_sample;
		r_d.trial = seq_trial;
		r_d.power = cif.enable;
		if (rd)
		begin
			unique case (adr)
				ADCSQ_ADR_CTRL:
					r_d.dat[7:0] = {r_q.done, r_q.speed, r_q.on,
						r_q.rsvd, r_q.ch};
				ADCSQ_ADR_RES_HIGH:
				begin
					r_d.dat[7:0] = cif.result[9:2];
					r_d.done = 1'b0;
				end
				ADCSQ_ADR_RES_LOW:
					r_d.dat[7:0] = {6'h00, cif.result[1:0]};
				ADCSQ_ADR_POWER:
					r_d.dat[ADCSQ_BIT_HALT] = halt_mode;
				default:
					r_d.dat = 32'h0000_0000;
			endcase
		end
		if (wr && wb_sel_i[0] && adr == ADCSQ_ADR_CTRL)
		begin
			// flag bit is not writable
			r_d.speed = wbyte[ADCSQ_BIT_SPEED];
			r_d.on = wbyte[ADCSQ_BIT_ON];
			r_d.rsvd = wbyte[ADCSQ_BIT_RSVD];
			r_d.ch = wbyte[ADCSQ_CH_MSB:0];
			r_d.done = 1'b0;
			if (wbyte[ADCSQ_CH_MSB:0] != r_q.ch)
				r_d.restart = 1'b1;
		end
		// completion wins over a same-cycle clear by read or write
		if (cif.done)
			r_d.done = 1'b1;
		if (r_q.restart)
			r_d.done = 1'b0;
		if (!cif.enable)
			r_d.done = r_d.done && !(r_q.on && !halt_mode);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign wb_dat_o = r_q.dat;
	assign wb_ack_o = r_q.ack;
	assign pin_digital_level = r_q.pins;
	assign mux_sel = r_q.mux;
	assign sample = r_q.samp;
	assign trial = r_q.trial;
	assign converter_power = r_q.power;

endmodule // adcsq_top
